// >>> rtl/smc_top.v
// Purpose: sensor monitor control - adc clocking, discard, averaging, history, bypass
// Assumes: 25 MHz system clock, adc symbols synchronous with valid strobe
// Notes:   registers are 16 bits wide at their printed offsets
//
// Functional notes
// - the dc offset comes from calibration logic when the source bit is 0, else programmed.
// - the eight-bit programmed offset in bits 15..8 applies only while the source bit is 1.
// - history clear set to 1 empties the sample history and holds it until written back to 0.
// - after adc enable, 3 symbols (setting 0) or 6 (setting 1, reset) are discarded.
// - three symbols are averaged per logged value for setting 0, five for setting 1.
// - adc clock is 12.5 MHz for code 0, 6.25 MHz for code 1, 3.125 MHz for codes 2 and 3.
// - monitors enable when the twisted-pair link is up, or under force enable, unless the hold reset bit is 1.
// - while the hold reset bit is 1 the monitors stay in reset; it resets to 1.
// - in bypass the sensor reset follows the bypass value: 0 holds reset, 1 releases.
// - the state machine controls the sensors unless the bypass bit is 1.
// - in bypass only the sensor picked by the three-bit select field is monitored.
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module smc_top #(
  parameter ADC_W       = 12,
  parameter NUM_SENSORS = 5,
  parameter HIST_DEPTH  = 8,
  parameter HIST_AW     = 3
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             srst_i,
  // register port
  input  wire [8:0]       addr_i,
  input  wire [15:0]      wdata_i,
  input  wire             wr_en_i,
  input  wire             rd_en_i,
  output reg  [15:0]      rdata_o,
  // link and calibration
  input  wire             link_up_i,
  input  wire [7:0]       cal_offset_i,
  // sensor adc
  input  wire             adc_sym_valid_i,
  input  wire [ADC_W-1:0] adc_sym_i,
  output reg              adc_clk_o,
  output reg              adc_en_o,
  output reg              sensor_rst_n_o,
  output reg  [2:0]       sensor_sel_o,
  output reg  [7:0]       dc_offset_o,
  // logged values
  output reg              avg_valid_o,
  output reg  [ADC_W-1:0] avg_data_o
);
  localparam [1:0] ST_IDLE    = 2'b00;
  localparam [1:0] ST_DISCARD = 2'b01;
  localparam [1:0] ST_AVG     = 2'b10;
  localparam [1:0] ST_LOG     = 2'b11;

  localparam integer HALF_FAST = `SMC_SYS_HZ / (2 * `SMC_ADC_HZ_FAST);
  localparam integer HALF_MID  = `SMC_SYS_HZ / (2 * `SMC_ADC_HZ_MID);
  localparam integer HALF_SLOW = `SMC_SYS_HZ / (2 * `SMC_ADC_HZ_SLOW);
  localparam integer ACC_W     = ADC_W + 3;

  // registers
  reg  [15:0]        ctrl_main_q;
  reg  [15:0]        offset_gain_q;
  reg  [15:0]        bypass_decim_q;
  reg  [15:0]        seq_bypass_q;

  // engine state
  reg  [1:0]         state_q;
  reg  [2:0]         sym_cnt_q;
  reg  [ACC_W-1:0]   acc_q;
  reg  [2:0]         seq_sel_q;
  reg  [2:0]         div_cnt_q;
  reg  [HIST_AW-1:0] hist_wptr_q;
  reg  [HIST_AW:0]   hist_fill_q;
  reg                mon_en_q;

  wire               hold_rst;
  wire               hist_clr;
  wire               fsm_bypass;
  wire               mon_en;
  wire [2:0]         discard_n;
  wire [2:0]         avg_n;
  wire [2:0]         half_per;
  wire [15:0]        acc16;
  wire [31:0]        prod3;
  wire [31:0]        prod5;
  wire [ADC_W-1:0]   avg_val;
  wire [ADC_W-1:0]   hist_rdata;
  wire [HIST_AW-1:0] hist_raddr;
  reg  [15:0]        rd_mux;

  // half period of the adc clock in system cycles
  function [2:0] adc_half;
    input [1:0] code;
    begin
      case (code)
        2'd0:    adc_half = HALF_FAST[2:0];
        2'd1:    adc_half = HALF_MID[2:0];
        default: adc_half = HALF_SLOW[2:0];
      endcase
    end
  endfunction

  assign hold_rst   = ctrl_main_q[`SMC_B_HOLD_RST];
  assign hist_clr   = ctrl_main_q[`SMC_B_HIST_CLR];
  assign fsm_bypass = seq_bypass_q[`SMC_B_FSM_BYPASS];
  // link up or force start, gated by the hold reset bit
  assign mon_en     = (link_up_i | ctrl_main_q[`SMC_B_FORCE_EN]) & ~hold_rst;
  assign discard_n  = ctrl_main_q[`SMC_B_DISCARD_SEL] ? 3'd`SMC_DISCARD_N1
                                                       : 3'd`SMC_DISCARD_N0;
  assign avg_n      = ctrl_main_q[`SMC_B_AVG_SEL] ? 3'd`SMC_AVG_N1 : 3'd`SMC_AVG_N0;
  assign half_per   = adc_half(ctrl_main_q[`SMC_F_ADC_DIV_HI:`SMC_F_ADC_DIV_LO]);

  // reciprocal multiply instead of a divider; exact while adc width stays at or below 13
  assign acc16   = {{(16 - ACC_W){1'b0}}, acc_q};
  assign prod3   = acc16 * `SMC_RECIP3;
  assign prod5   = acc16 * `SMC_RECIP5;
  assign avg_val = ctrl_main_q[`SMC_B_AVG_SEL]
                 ? prod5[`SMC_RECIP5_SH +: ADC_W]
                 : prod3[`SMC_RECIP3_SH +: ADC_W];

  // register writes
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_main_q    <= `SMC_RST_CTRL_MAIN;
      offset_gain_q  <= `SMC_RST_OFFSET_GAIN;
      bypass_decim_q <= `SMC_RST_BYPASS_DECIM;
      seq_bypass_q   <= `SMC_RST_SEQ_BYPASS;
    end else if (wr_en_i) begin
      case (addr_i)
        `SMC_ADDR_CTRL_MAIN:    ctrl_main_q    <= wdata_i;
        `SMC_ADDR_OFFSET_GAIN:  offset_gain_q  <= wdata_i;
        `SMC_ADDR_BYPASS_DECIM: bypass_decim_q <= wdata_i;
        `SMC_ADDR_SEQ_BYPASS:   seq_bypass_q   <= wdata_i;
        default: ;
      endcase
    end
  end

  // adc clock divider; runs only while the monitors are enabled
  always @(posedge clk_sys_i) begin
    if (srst_i || !mon_en) begin
      div_cnt_q <= 3'd0;
      adc_clk_o <= 1'b0;
    end else if (div_cnt_q + 3'd1 >= half_per) begin
      div_cnt_q <= 3'd0;
      adc_clk_o <= ~adc_clk_o;
    end else begin
      div_cnt_q <= div_cnt_q + 3'd1;
    end
  end

  // discard, average and log
  always @(posedge clk_sys_i) begin
    if (srst_i || hold_rst) begin
      state_q   <= ST_IDLE;
      sym_cnt_q <= 3'd0;
      acc_q     <= {ACC_W{1'b0}};
      seq_sel_q <= 3'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sym_cnt_q <= 3'd0;
          acc_q     <= {ACC_W{1'b0}};
          if (mon_en) begin
            state_q <= ST_DISCARD;
          end
        end
        ST_DISCARD: begin
          if (!mon_en) begin
            state_q <= ST_IDLE;
          end else if (adc_sym_valid_i) begin
            if (sym_cnt_q + 3'd1 == discard_n) begin
              sym_cnt_q <= 3'd0;
              state_q   <= ST_AVG;
            end else begin
              sym_cnt_q <= sym_cnt_q + 3'd1;
            end
          end
        end
        ST_AVG: begin
          if (!mon_en) begin
            state_q <= ST_IDLE;
          end else if (adc_sym_valid_i) begin
            acc_q <= acc_q + {3'b000, adc_sym_i};
            if (sym_cnt_q + 3'd1 == avg_n) begin
              sym_cnt_q <= 3'd0;
              state_q   <= ST_LOG;
            end else begin
              sym_cnt_q <= sym_cnt_q + 3'd1;
            end
          end
        end
        ST_LOG: begin
          acc_q   <= {ACC_W{1'b0}};
          state_q <= mon_en ? ST_AVG : ST_IDLE;
          // sequencer walks all sensors; frozen while bypassed
          if (!fsm_bypass) begin
            seq_sel_q <= (seq_sel_q == NUM_SENSORS - 1) ? 3'd0 : seq_sel_q + 3'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // logged value and sensor-side outputs
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      avg_valid_o    <= 1'b0;
      avg_data_o     <= {ADC_W{1'b0}};
      adc_en_o       <= 1'b0;
      sensor_rst_n_o <= 1'b0;
      sensor_sel_o   <= 3'd0;
      dc_offset_o    <= 8'h0_0;
      mon_en_q       <= 1'b0;
    end else begin
      avg_valid_o <= (state_q == ST_LOG);
      if (state_q == ST_LOG) begin
        avg_data_o <= avg_val;
      end
      mon_en_q <= mon_en;
      adc_en_o <= mon_en;
      if (fsm_bypass) begin
        sensor_rst_n_o <= bypass_decim_q[`SMC_B_BYP_RST_VAL];
        sensor_sel_o   <= bypass_decim_q[`SMC_F_BYP_SEL_HI:`SMC_F_BYP_SEL_LO];
      end else begin
        sensor_rst_n_o <= mon_en;
        sensor_sel_o   <= seq_sel_q;
      end
      dc_offset_o <= ctrl_main_q[`SMC_B_OFFSET_SRC]
                   ? offset_gain_q[`SMC_F_OFFSET_HI:`SMC_F_OFFSET_LO]
                   : cal_offset_i;
    end
  end

  // history pointer and fill level; clear holds while the bit stays at 1
  always @(posedge clk_sys_i) begin
    if (srst_i || hist_clr) begin
      hist_wptr_q <= {HIST_AW{1'b0}};
      hist_fill_q <= {(HIST_AW + 1){1'b0}};
    end else if (state_q == ST_LOG) begin
      hist_wptr_q <= hist_wptr_q + {{(HIST_AW - 1){1'b0}}, 1'b1};
      if (hist_fill_q != HIST_DEPTH[HIST_AW:0]) begin
        hist_fill_q <= hist_fill_q + {{HIST_AW{1'b0}}, 1'b1};
      end
    end
  end

  assign hist_raddr = hist_wptr_q - {{(HIST_AW - 1){1'b0}}, 1'b1};

  smc_hist_mem #(
    .W     (ADC_W),
    .DEPTH (HIST_DEPTH),
    .AW    (HIST_AW)
  ) u_hist (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .we_i      (state_q == ST_LOG && !hist_clr),
    .waddr_i   (hist_wptr_q),
    .wdata_i   (avg_val),
    .raddr_i   (hist_raddr),
    .rdata_q   (hist_rdata)
  );

  // read mux; unmapped offsets read zero
  always @* begin
    rd_mux = 16'h0_000;
    case (addr_i)
      `SMC_ADDR_CTRL_MAIN:    rd_mux = ctrl_main_q;
      `SMC_ADDR_OFFSET_GAIN:  rd_mux = offset_gain_q;
      `SMC_ADDR_BYPASS_DECIM: rd_mux = bypass_decim_q;
      `SMC_ADDR_SEQ_BYPASS:   rd_mux = seq_bypass_q;
      `SMC_ADDR_READBACK: begin
        if (hist_fill_q != {(HIST_AW + 1){1'b0}}) begin
          rd_mux[ADC_W-1:0] = hist_rdata;
        end
      end
      `SMC_ADDR_STATUS: begin
        rd_mux[`SMC_F_ST_SEL_LO +: 3]             = sensor_sel_o;
        rd_mux[`SMC_F_ST_STATE_LO +: 2]           = state_q;
        rd_mux[`SMC_B_ST_ENABLED]                 = mon_en_q;
        rd_mux[`SMC_F_ST_FILL_LO +: (HIST_AW + 1)] = hist_fill_q;
      end
      default: rd_mux = 16'h0_000;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0_000;
    end else if (rd_en_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 16'h0_000;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/smc_regs.vh
// Purpose: offsets, field positions, reset values and timing for the sensor monitor control
// Assumes: 16-bit registers reached at their printed offsets over a plain port
// Notes:   included by bare name
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// register offsets
`define SMC_ADDR_CTRL_MAIN      9'h1_e2
`define SMC_ADDR_OFFSET_GAIN    9'h1_e7
`define SMC_ADDR_BYPASS_DECIM   9'h1_e8
`define SMC_ADDR_SEQ_BYPASS     9'h1_e9
`define SMC_ADDR_READBACK       9'h1_ea
`define SMC_ADDR_STATUS         9'h1_eb

// reset values
`define SMC_RST_CTRL_MAIN       16'h0_025
`define SMC_RST_OFFSET_GAIN     16'h0_012
`define SMC_RST_BYPASS_DECIM    16'h0_920
`define SMC_RST_SEQ_BYPASS      16'h0_36d

// control main fields
`define SMC_B_OFFSET_SRC        15
`define SMC_B_HIST_CLR          6
`define SMC_B_DISCARD_SEL       5
`define SMC_B_AVG_SEL           4
`define SMC_F_ADC_DIV_HI        3
`define SMC_F_ADC_DIV_LO        2
`define SMC_B_FORCE_EN          1
`define SMC_B_HOLD_RST          0

// offset / bypass fields
`define SMC_F_OFFSET_HI         15
`define SMC_F_OFFSET_LO         8
`define SMC_B_BYP_RST_VAL       15
`define SMC_F_BYP_SEL_HI        2
`define SMC_F_BYP_SEL_LO        0
`define SMC_B_FSM_BYPASS        14

// status fields
`define SMC_F_ST_SEL_LO         0
`define SMC_F_ST_STATE_LO       3
`define SMC_B_ST_ENABLED        5
`define SMC_F_ST_FILL_LO        6

// symbol counts
`define SMC_DISCARD_N0          3
`define SMC_DISCARD_N1          6
`define SMC_AVG_N0              3
`define SMC_AVG_N1              5

// timing
`define SMC_SYS_HZ              25000000
`define SMC_ADC_HZ_FAST         12500000
`define SMC_ADC_HZ_MID          6250000
`define SMC_ADC_HZ_SLOW         3125000

// reciprocal multipliers, exact floor for 16-bit sums
`define SMC_RECIP3              16'ha_aab
`define SMC_RECIP3_SH           17
`define SMC_RECIP5              16'hc_ccd
`define SMC_RECIP5_SH           18

`endif

// >>> rtl/smc_hist_mem.v
// Purpose: sample history store for upset detection
// Assumes: one write and one read port, same clock
// Notes:   read data registered; contents are not cleared, only the write pointer and fill count are
`timescale 1ns/1ps
`default_nettype none
module smc_hist_mem #(
  parameter W     = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire          clk_sys_i,
  input  wire          srst_i,
  // write port
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [W-1:0]  wdata_i,
  // read port
  input  wire [AW-1:0] raddr_i,
  output reg  [W-1:0]  rdata_q
);
  reg [W-1:0] mem [0:DEPTH-1];

  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_q <= {W{1'b0}};
    end else begin
      rdata_q <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// >>> bench/smc_top_properties.sv
// Purpose: port checks for the sensor monitor control
// Assumes: values written on the port mirror the control registers
// Notes:   bound into smc_top
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module smc_chk (
  // clock, reset, register port
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [8:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] rdata_o,
  // monitor side
  input wire logic        link_up_i,
  input wire logic [7:0]  cal_offset_i,
  input wire logic        adc_clk_o,
  input wire logic        adc_en_o,
  input wire logic        sensor_rst_n_o,
  input wire logic [2:0]  sensor_sel_o,
  input wire logic [7:0]  dc_offset_o,
  input wire logic        avg_valid_o
);
  logic [15:0] ctl_q, ofs_q, bd_q, sb_q;
  logic [2:0]  hi_q, half;
  // codes 2 and 3 share the slowest rate
  assign half = (ctl_q[3:2] == 2'd0) ? 3'd1 : (ctl_q[3:2] == 2'd1) ? 3'd2 : 3'd4;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hi_q  <= 3'd0;
      ctl_q <= `SMC_RST_CTRL_MAIN;
      ofs_q <= `SMC_RST_OFFSET_GAIN;
      bd_q  <= `SMC_RST_BYPASS_DECIM;
      sb_q  <= `SMC_RST_SEQ_BYPASS;
    end else begin
      hi_q <= adc_clk_o ? hi_q + 3'd1 : 3'd0;
      if (wr_en_i && addr_i == `SMC_ADDR_CTRL_MAIN) ctl_q <= wdata_i;
      if (wr_en_i && addr_i == `SMC_ADDR_OFFSET_GAIN) ofs_q <= wdata_i;
      if (wr_en_i && addr_i == `SMC_ADDR_BYPASS_DECIM) bd_q <= wdata_i;
      if (wr_en_i && addr_i == `SMC_ADDR_SEQ_BYPASS) sb_q <= wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  offset_source_a: assert property (
    !$past(srst_i) |-> dc_offset_o == $past(ctl_q[15] ? ofs_q[15:8] : cal_offset_i))
    else $error("dc offset from wrong source");
  monitor_enable_a: assert property (
    !$past(srst_i) |-> adc_en_o == $past((link_up_i | ctl_q[1]) & ~ctl_q[0]))
    else $error("monitor enable wrong");
  hold_idle_a: assert property (
    ctl_q[0] [*3] |-> !adc_en_o && !avg_valid_o)
    else $error("activity while held in reset");
  adc_clk_half_a: assert property (
    $fell(adc_clk_o) && adc_en_o && $past(adc_en_o) && !ctl_q[0] |-> hi_q == half)
    else $error("adc clock high time wrong");
  bypass_reset_a: assert property (
    !$past(srst_i) && $past(sb_q[14]) |-> sensor_rst_n_o == $past(bd_q[15]))
    else $error("bypass sensor reset wrong");
  bypass_select_a: assert property (
    !$past(srst_i) && $past(sb_q[14]) |-> sensor_sel_o == $past(bd_q[2:0]))
    else $error("bypass sensor select wrong");
  avg_pulse_a: assert property (
    avg_valid_o |=> !avg_valid_o)
    else $error("log strobe longer than one cycle");
  hist_clear_a: assert property (
    ctl_q[6] [*3] ##0 (rd_en_i && addr_i == `SMC_ADDR_READBACK) |=> rdata_o == 16'h0000)
    else $error("history not empty while cleared");
  cover property (avg_valid_o && ctl_q[4]);
  cover property ($fell(adc_clk_o) && ctl_q[3:2] == 2'd3);
  cover property (sb_q[14] && !sensor_rst_n_o);
endmodule
bind smc_top smc_chk chk_u (.clk_sys_i, .srst_i, .addr_i, .wdata_i, .wr_en_i, .rd_en_i,
  .rdata_o, .link_up_i, .cal_offset_i, .adc_clk_o, .adc_en_o, .sensor_rst_n_o,
  .sensor_sel_o, .dc_offset_o, .avg_valid_o);
`default_nettype wire

// >>> bench/smc_adc_model.sv
// Purpose: sensor adc seen from the monitor control
// Assumes: one symbol per adc clock rise while enabled and out of reset
// Notes:   slow mode skips every other rise to stall the stream
`timescale 1ns/1ps
`default_nettype none
module smc_adc_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // controls from the monitor, plus the bench slow select and symbol source
  input  wire logic        adc_clk_i,
  input  wire logic        adc_en_i,
  input  wire logic        sensor_rst_n_i,
  input  wire logic        slow_i,
  input  wire logic [11:0] sym_i,
  // symbols
  output logic             sym_valid_o,
  output logic [11:0]      sym_o
);
  logic clk_d_q, skip_q;
  initial {sym_valid_o, sym_o, clk_d_q, skip_q} = '0;
  always @(posedge clk_sys_i) begin
    clk_d_q <= adc_clk_i;
    sym_valid_o <= 1'b0;
    // idle bus is not left showing the last symbol
    sym_o <= ~sym_o;
    if (srst_i) begin
      skip_q <= 1'b0;
    end else if (adc_clk_i && !clk_d_q && adc_en_i && sensor_rst_n_i) begin
      skip_q <= slow_i && !skip_q;
      if (!skip_q) begin
        sym_valid_o <= 1'b1;
        sym_o <= sym_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/sensor_monitor_control_tb.sv
// Purpose: self-checking bench for the sensor monitor control
// Assumes: adc model answers on adc clock rises
// Notes:   averages are predicted from the symbols seen at the ports
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module sensor_monitor_control_tb;
  logic        clk_sys_i, srst_i, wr_en_i, rd_en_i, link_up_i, slow;
  logic        adc_sym_valid_i, adc_clk_o, adc_en_o, sensor_rst_n_o, avg_valid_o;
  logic [8:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic [7:0]  cal_offset_i, dc_offset_o;
  logic [11:0] adc_sym_i, avg_data_o, rnd_sym, last;
  logic [2:0]  sensor_sel_o;
  logic [11:0] expq[$];
  int          seed, num_errors, checks_done, disc_n, avg_n, cnt, n, sum, logs, i, k;

  smc_top dut_u (.clk_sys_i, .srst_i, .addr_i, .wdata_i, .wr_en_i, .rd_en_i, .rdata_o,
    .link_up_i, .cal_offset_i, .adc_sym_valid_i, .adc_sym_i, .adc_clk_o, .adc_en_o,
    .sensor_rst_n_o, .sensor_sel_o, .dc_offset_o, .avg_valid_o, .avg_data_o);
  smc_adc_model adc_u (.clk_sys_i, .srst_i, .adc_clk_i(adc_clk_o), .adc_en_i(adc_en_o),
    .sensor_rst_n_i(sensor_rst_n_o), .slow_i(slow), .sym_i(rnd_sym),
    .sym_valid_o(adc_sym_valid_i), .sym_o(adc_sym_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) rnd_sym <= 12'($random(seed));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
    #1 chk(rdata_o, e);
    @(posedge clk_sys_i);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // log check runs before the clear so a log landing as the hold bites still matches
  always @(negedge clk_sys_i) begin
    if (avg_valid_o === 1'b1) begin
      logs++;
      last = avg_data_o;
      if (expq.size() == 0) chk(16'hffff, 16'h0000);
      else chk(16'(avg_data_o), 16'(expq.pop_front()));
    end
    if (srst_i || adc_en_o !== 1'b1) begin
      cnt = 0;
      n = 0;
      sum = 0;
      expq.delete();
    end else if (adc_sym_valid_i) begin
      if (cnt < disc_n) cnt++;
      else begin
        sum += adc_sym_i;
        n++;
      end
      if (n == avg_n) begin
        expq.push_back(12'(sum / avg_n));
        n = 0;
        sum = 0;
      end
    end
  end

  initial begin
    #(40 * 20000);
    num_errors++;
    finish_test();
  end

  initial begin
    seed = 53;
    num_errors = 0;
    checks_done = 0;
    logs = 0;
    disc_n = 6;
    avg_n = 3;
    {srst_i, wr_en_i, rd_en_i, link_up_i, slow} = 5'b10000;
    addr_i = 9'h000;
    wdata_i = 16'h0000;
    cal_offset_i = 8'h00;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(`SMC_ADDR_CTRL_MAIN, `SMC_RST_CTRL_MAIN);
    rd(`SMC_ADDR_OFFSET_GAIN, `SMC_RST_OFFSET_GAIN);
    rd(`SMC_ADDR_BYPASS_DECIM, `SMC_RST_BYPASS_DECIM);
    rd(`SMC_ADDR_SEQ_BYPASS, `SMC_RST_SEQ_BYPASS);
    wr(9'h1_e3, 16'hffff);
    rd(9'h1_e3, 16'h0000);
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      cal_offset_i <= v[7:0];
      wr(`SMC_ADDR_OFFSET_GAIN, {v[15:8], 8'h12});
      wr(`SMC_ADDR_CTRL_MAIN, {i[0], 15'h0025});
      repeat (2) @(posedge clk_sys_i);
      #1 chk(16'(dc_offset_o), 16'(i[0] ? v[15:8] : v[7:0]));
    end
    for (i = 0; i < 8; i++) begin
      link_up_i <= i[2];
      wr(`SMC_ADDR_CTRL_MAIN, {14'h0009, i[1], i[0]});
      repeat (2) @(posedge clk_sys_i);
      #1 chk(16'(adc_en_o), 16'((i[2] | i[1]) & ~i[0]));
    end
    link_up_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(`SMC_ADDR_CTRL_MAIN, {12'h002, i[1:0], 2'b11});
      wr(`SMC_ADDR_CTRL_MAIN, {12'h002, i[1:0], 2'b10});
      repeat (10) @(negedge clk_sys_i);
      while (adc_clk_o !== 1'b0) @(negedge clk_sys_i);
      while (adc_clk_o !== 1'b1) @(negedge clk_sys_i);
      k = 0;
      while (adc_clk_o === 1'b1 && k < 9) begin
        k++;
        @(negedge clk_sys_i);
      end
      chk(16'(k), 16'(i == 0 ? 1 : i == 1 ? 2 : 4));
      @(posedge clk_sys_i);
    end
    // counts change only while held, so each release starts a fresh discard
    for (i = 0; i < 4; i++) begin
      wr(`SMC_ADDR_CTRL_MAIN, {10'h000, i[1], i[0], 4'h3});
      repeat (3) @(posedge clk_sys_i);
      disc_n = i[1] ? 6 : 3;
      avg_n = i[0] ? 5 : 3;
      slow <= i[0];
      wr(`SMC_ADDR_CTRL_MAIN, {10'h000, i[1], i[0], 4'h2});
      k = logs;
      repeat (400) if (logs < k + 3) @(posedge clk_sys_i);
      chk(16'(logs - k >= 3), 16'h0001);
    end
    wr(`SMC_ADDR_CTRL_MAIN, 16'h0072);
    repeat (20) @(posedge clk_sys_i);
    rd(`SMC_ADDR_READBACK, 16'h0000);
    wr(`SMC_ADDR_CTRL_MAIN, 16'h0032);
    k = logs;
    repeat (200) if (logs == k) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
    rd(`SMC_ADDR_READBACK, {4'h0, last});
    wr(`SMC_ADDR_CTRL_MAIN, 16'h0033);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(16'(sensor_rst_n_o), 16'h0000);
    wr(`SMC_ADDR_SEQ_BYPASS, 16'h436d);
    for (i = 0; i < 16; i++) begin
      wr(`SMC_ADDR_BYPASS_DECIM, {i[3], 12'h124, i[2:0]});
      repeat (2) @(posedge clk_sys_i);
      #1 chk(16'({sensor_rst_n_o, sensor_sel_o}), 16'(i[3:0]));
    end
    finish_test();
  end
endmodule
`default_nettype wire
